// File: rps_top.sv
// Rx payload and rx signaling buffer control registers with datapath
`timescale 1ns/1ps
`include "rps_defs.svh"
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Transmit payload enable bit switches all transmit payload functions.
// - Receive payload enable bit 0, reset 0, switches payload replacement, snapshot and trunk conditioning.
// - Each access status shows busy 1 during an indirect access, else 0.
// - Access control bit 7 is direction, 1 read; bits 6..0 address.
// - Payload indirect addresses 00-3F, 41-4F and 51-5F are valid.
// - Signaling indirect addresses 01-0F and 11-1F are valid.
// - Read: write address with direction 1; byte lands in data register.
// - Snapshot with multiframe sync repeats first frame ABCD all multiframe.
// - Global trunk bit forces conditioning ABCD; else per-slot enable does.
// - Global selector 000 uses each slot's own replacement field.
// - Global selector 001 sends each slot's data trunk code.
// - Selector 010 sends A-law, 011 mu-law milliwatt; others reserved.
// - Freeze holds stored ABCD at their previous value.
// - Debounce updates stored ABCD after two identical codewords only.
// - Interrupt enable drives interrupt while any change flag is set.
// - A change of stored ABCD sets that slot's change flag.
// - Writing 1 clears a change flag; writing 0 leaves it.
// - Flags 1-15 map to slots 1-15, flags 16-24 to slots 17-25.
// - Flags 25-30 in the fourth register map to slots 26-31.
module rps_top #(
    parameter int ACC_CYCLES = `RPS_ACC_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Received payload stream
    input wire logic pay_v_i,
    input wire rps_pkg::rps_slot_type pay_slot_i,
    input wire rps_pkg::rps_byte_type pay_data_i,
    output logic rx_payload_valid_o,
    output rps_pkg::rps_byte_type rx_payload_o,
    // Received signaling stream
    input wire logic sig_v_i,
    input wire rps_pkg::rps_slot_type sig_slot_i,
    input wire rps_pkg::rps_abcd_type sig_abcd_i,
    input wire logic sig_first_i,
    input wire logic mf_sync_i,
    output logic rx_sig_valid_o,
    output rps_pkg::rps_abcd_type rx_signaling_out_o,
    // Status and control
    output logic irq_o,
    output logic tx_payload_ctrl_en_o
);
    import rps_pkg::*;
    localparam int ACC_BOUND = 64;

    if (ACC_CYCLES < 1 || ACC_CYCLES > ACC_BOUND) begin : g_chk
        $error("ACC_CYCLES out of range");
    end

    // Address window check shared by both indirect windows
    function automatic logic addr_ok(input logic [6:0] a,
            input logic [6:0] top, input logic [6:0] h0,
            input logic [6:0] h1);
        addr_ok = (a <= top) && (a != h0) && (a != h1);
    endfunction

    // One-hot change flag of a timeslot; slots 0 and 16 have none
    function automatic logic [29:0] flag_of(input rps_slot_type s);
        flag_of = '0;
        if (s > `RPS_SLOT_MF) begin
            flag_of[5'(s - `RPS_FLAG_OFS_HI)] = 1'b1;
        end else if (s != `RPS_SLOT_FAS && s != `RPS_SLOT_MF) begin
            flag_of[5'(s - `RPS_FLAG_OFS_LO)] = 1'b1;
        end
    endfunction

    // Byte of a milliwatt sequence at a frame phase
    function automatic rps_byte_type dmw(input logic [63:0] p,
            input logic [2:0] ph);
        dmw = p[{ph, 3'h0} +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; a request is taken once, in the cycle before ack
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] cix;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign cix = idx - `RPS_IX_CHG0;

    logic [7:0] pcfg;
    logic pen;
    logic [7:0] scfg;
    logic [7:0] pctl;
    logic [7:0] pdat;
    logic [7:0] sctl;
    logic [7:0] sdat;
    logic [29:0] chg;
    logic [7:0] pmem [0:`RPS_PMEM_N-1];
    rps_abcd_type sig_st [0:31];
    rps_abcd_type sig_last [0:31];
    rps_abcd_type snap [0:31];
    logic [2:0] ph;

    ////////////////////////////////////////////////////////////////////////
    // Indirect access sequencers; a start while busy is dropped
    logic p_start;
    logic p_busy;
    logic p_fire;
    logic s_start;
    logic s_busy;
    logic s_fire;
    logic p_ok;
    logic s_ok;
    assign p_start = wr && idx == `RPS_IX_PCTL && !p_busy;
    assign s_start = wr && idx == `RPS_IX_SCTL && !s_busy;
    assign p_ok = addr_ok(pctl[`RPS_F_ADDR], `RPS_PA_END,
        `RPS_PA_HOLE0, `RPS_PA_HOLE1);
    assign s_ok = addr_ok(sctl[`RPS_F_ADDR], `RPS_SA_END,
        `RPS_SA_HOLE0, `RPS_SA_HOLE1);

    rps_access_seq #(.CYCLES(ACC_CYCLES)) u_pseq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(p_start),
        .busy_o(p_busy),
        .fire_o(p_fire)
    );

    rps_access_seq #(.CYCLES(ACC_CYCLES)) u_sseq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(s_start),
        .busy_o(s_busy),
        .fire_o(s_fire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Direct control registers; reserved bits are never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_payload_ctrl_en_o <= 1'b0;
            pcfg <= `RPS_RST8;
            pen <= 1'b0;
            scfg <= `RPS_RST8;
        end else if (wr) begin
            if (idx == `RPS_IX_TXEN)
                tx_payload_ctrl_en_o <= wb_dat_i[`RPS_B_EN];
            if (idx == `RPS_IX_PCFG)
                pcfg <= wb_dat_i[7:0] & `RPS_PCFG_MASK;
            if (idx == `RPS_IX_PEN)
                pen <= wb_dat_i[`RPS_B_EN];
            if (idx == `RPS_IX_SCFG)
                scfg <= wb_dat_i[7:0] & `RPS_SCFG_MASK;
        end
    end

    // Access control words; held still while their access runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pctl <= `RPS_RST8;
            sctl <= `RPS_RST8;
        end else begin
            if (p_start)
                pctl <= wb_dat_i[7:0];
            if (s_start)
                sctl <= wb_dat_i[7:0];
        end
    end

    // Payload data register: host load, or read result at access end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pdat <= `RPS_RST8;
        end else if (p_fire && pctl[`RPS_B_RD]) begin
            pdat <= p_ok ? pmem[pctl[`RPS_F_ADDR]] : `RPS_RST8;
        end else if (wr && idx == `RPS_IX_PDAT && !p_busy) begin
            pdat <= wb_dat_i[7:0];
        end
    end

    // Signaling data register; stored ABCD sit in the low nibble
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdat <= `RPS_RST8;
        end else if (s_fire && sctl[`RPS_B_RD]) begin
            sdat <= s_ok ? {4'h0, sig_st[sctl[4:0]]} : `RPS_RST8;
        end else if (wr && idx == `RPS_IX_SDAT && !s_busy) begin
            sdat <= wb_dat_i[7:0];
        end
    end

    // Payload indirect store; holes and out-of-window writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `RPS_PMEM_N; i++) begin
                pmem[i] <= `RPS_RST8;
            end
        end else if (p_fire && !pctl[`RPS_B_RD] && p_ok) begin
            pmem[pctl[`RPS_F_ADDR]] <= pdat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Signaling path: snapshot, debounce, freeze and change detection
    rps_abcd_type eff;
    rps_abcd_type cond;
    logic upd;
    logic [29:0] set;
    logic [31:0] clr;
    assign cond = pmem[`RPS_COND_BASE + {2'h0, sig_slot_i}][`RPS_F_ABCD];

    always_comb begin
        eff = sig_abcd_i;
        if (pen && pcfg[`RPS_B_SNAP] && mf_sync_i && !sig_first_i)
            eff = snap[sig_slot_i];
        upd = sig_v_i && !scfg[`RPS_B_FRZ] &&
            (!scfg[`RPS_B_DBNC] || eff == sig_last[sig_slot_i]);
        set = '0;
        if (upd && eff != sig_st[sig_slot_i])
            set = flag_of(sig_slot_i);
    end

    // First-frame codewords are caught for the rest of the multiframe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 32; i++) begin
                snap[i] <= '0;
                sig_last[i] <= '0;
            end
        end else if (sig_v_i) begin
            sig_last[sig_slot_i] <= eff;
            if (sig_first_i)
                snap[sig_slot_i] <= sig_abcd_i;
        end
    end

    // Stored ABCD; a host write lands after the stream update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 32; i++) begin
                sig_st[i] <= '0;
            end
        end else begin
            if (upd)
                sig_st[sig_slot_i] <= eff;
            if (s_fire && !sctl[`RPS_B_RD] && s_ok)
                sig_st[sctl[4:0]] <= sdat[`RPS_F_ABCD];
        end
    end

    // Clear mask from a write to one of the four flag registers
    always_comb begin
        clr = '0;
        if (wr && idx >= `RPS_IX_CHG0 && idx <= `RPS_IX_CHG3)
            clr = {24'h0, wb_dat_i[7:0]} << {cix[1:0], 3'h0};
    end

    // Change flags; a new change in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chg <= '0;
        end else begin
            chg <= (chg & ~clr[29:0]) | set;
        end
    end

    // Interrupt level follows the enable and any pending flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= scfg[`RPS_B_IRQEN] && |chg;
        end
    end

    // Conditioning overrides the signaling sent on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_sig_valid_o <= 1'b0;
            rx_signaling_out_o <= '0;
        end else begin
            rx_sig_valid_o <= sig_v_i;
            if (pen && (pcfg[`RPS_B_GTRK] || cond_en()))
                rx_signaling_out_o <= cond;
            else
                rx_signaling_out_o <= eff;
        end
    end

    // Per-slot trunk enable of the slot now on the signaling stream
    function automatic logic cond_en();
        cond_en = pmem[`RPS_COND_BASE + {2'h0, sig_slot_i}][`RPS_B_STRK];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Payload replacement; reserved selector codes pass data through
    logic [2:0] psel;
    rps_byte_type pout;
    always_comb begin
        psel = pcfg[`RPS_F_GSEL];
        if (psel == `RPS_SEL_SLOT)
            psel = pmem[{2'h0, pay_slot_i}][`RPS_F_PSEL];
        pout = pay_data_i;
        if (pen) begin
            case (psel)
                `RPS_SEL_TRK:
                    pout = pmem[`RPS_TRK_BASE + {2'h0, pay_slot_i}];
                `RPS_SEL_ALAW: pout = dmw(`RPS_DMW_A, ph);
                `RPS_SEL_MULAW: pout = dmw(`RPS_DMW_MU, ph);
                default: pout = pay_data_i;
            endcase
        end
    end

    // Milliwatt phase steps once per frame, after the last slot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph <= 3'h0;
        end else if (pay_v_i && pay_slot_i == `RPS_SLOT_LAST) begin
            ph <= ph + 3'h1;
        end
    end

    // Registered payload output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_payload_valid_o <= 1'b0;
            rx_payload_o <= '0;
        end else begin
            rx_payload_valid_o <= pay_v_i;
            rx_payload_o <= pout;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux; unmapped indices read zero and still ack
    logic [7:0] rdat;
    always_comb begin
        case (idx)
            `RPS_IX_TXEN: rdat = {7'h0, tx_payload_ctrl_en_o};
            `RPS_IX_PSTAT: rdat = {7'h0, p_busy};
            `RPS_IX_PCTL: rdat = pctl;
            `RPS_IX_PDAT: rdat = pdat;
            `RPS_IX_PCFG: rdat = pcfg;
            `RPS_IX_PEN: rdat = {7'h0, pen};
            `RPS_IX_SCFG: rdat = scfg;
            `RPS_IX_SSTAT: rdat = {7'h0, s_busy};
            `RPS_IX_SCTL: rdat = sctl;
            `RPS_IX_SDAT: rdat = sdat;
            `RPS_IX_CHG0, `RPS_IX_CHG1, `RPS_IX_CHG2, `RPS_IX_CHG3:
                rdat = 8'({2'h0, chg} >> {cix[1:0], 3'h0});
            default: rdat = `RPS_RST8;
        endcase
    end

    // Ack one cycle after the request; data captured with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
                wb_dat_o <= {24'h0, rdat};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_pay_read;
        p_fire && pctl[`RPS_B_RD] && p_ok;
    endsequence

    a_tx_enable: assert property (wr && idx == `RPS_IX_TXEN |=>
        tx_payload_ctrl_en_o == $past(wb_dat_i[0]))
        else $error("tx payload enable not stored");
    a_pay_bypass: assert property (pay_v_i && !pen |=>
        rx_payload_o == $past(pay_data_i))
        else $error("payload altered while disabled");
    a_busy_ends: assert property ($rose(p_busy) |->
        ##[1:ACC_BOUND] $fell(p_busy)) else $error("busy never ends");
    a_read_byte: assert property (s_pay_read |=> !p_busy &&
        pdat == $past(pmem[pctl[`RPS_F_ADDR]]))
        else $error("read byte missing when busy fell");
    a_bad_read: assert property (p_fire && pctl[`RPS_B_RD] && !p_ok
        |=> pdat == `RPS_RST8) else $error("hole read not zero");
    a_trunk_cond: assert property (sig_v_i && pen &&
        pcfg[`RPS_B_GTRK] |=> rx_signaling_out_o == $past(cond))
        else $error("trunk conditioning not applied");
    a_trunk_data: assert property (pay_v_i && pen &&
        pcfg[`RPS_F_GSEL] == `RPS_SEL_TRK |=> rx_payload_o ==
        $past(pmem[`RPS_TRK_BASE + {2'h0, pay_slot_i}]))
        else $error("data trunk code not applied");
    a_irq_level: assert property (##1 irq_o ==
        $past(scfg[`RPS_B_IRQEN] && |chg)) else $error("irq wrong");
    a_flag_set: assert property (|set |=> |chg)
        else $error("change flag lost");
    a_flag_clear: assert property (wr && idx == `RPS_IX_CHG0 &&
        wb_dat_i[0] && !set[0] |=> !chg[0])
        else $error("flag not cleared");
    a_freeze: assert property (sig_v_i && scfg[`RPS_B_FRZ] |->
        !upd && set == '0) else $error("frozen slot updated");
endmodule

// File: rps_defs.svh
// Register indices, field positions, codes and reset values of the block
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH
// Register indices; the byte address is four times the index
`define RPS_IX_TXEN 8'hcc
`define RPS_IX_PSTAT 8'hcd
`define RPS_IX_PCTL 8'hce
`define RPS_IX_PDAT 8'hcf
`define RPS_IX_PCFG 8'hd0
`define RPS_IX_PEN 8'hd1
`define RPS_IX_SCFG 8'hd2
`define RPS_IX_SSTAT 8'hd3
`define RPS_IX_SCTL 8'hd4
`define RPS_IX_SDAT 8'hd5
`define RPS_IX_CHG0 8'hd6
`define RPS_IX_CHG1 8'hd7
`define RPS_IX_CHG2 8'hd8
`define RPS_IX_CHG3 8'hd9
// Reset value and writable masks
`define RPS_RST8 8'h00
`define RPS_PCFG_MASK 8'hc7
`define RPS_SCFG_MASK 8'h0e
// Field positions
`define RPS_B_EN 0
`define RPS_B_BUSY 0
`define RPS_B_RD 7
`define RPS_F_ADDR 6:0
`define RPS_B_SNAP 7
`define RPS_B_GTRK 6
`define RPS_F_GSEL 2:0
`define RPS_B_FRZ 3
`define RPS_B_DBNC 2
`define RPS_B_IRQEN 1
`define RPS_F_PSEL 7:5
`define RPS_B_STRK 4
`define RPS_F_ABCD 3:0
// Replacement selector codes
`define RPS_SEL_SLOT 3'h0
`define RPS_SEL_TRK 3'h1
`define RPS_SEL_ALAW 3'h2
`define RPS_SEL_MULAW 3'h3
// Indirect address map
`define RPS_PMEM_N 96
`define RPS_TRK_BASE 7'h20
`define RPS_COND_BASE 7'h40
`define RPS_PA_END 7'h5f
`define RPS_PA_HOLE0 7'h40
`define RPS_PA_HOLE1 7'h50
`define RPS_SA_END 7'h1f
`define RPS_SA_HOLE0 7'h00
`define RPS_SA_HOLE1 7'h10
// Timeslots without a change flag, the last timeslot, and flag index offsets
`define RPS_SLOT_FAS 5'h00
`define RPS_SLOT_MF 5'h10
`define RPS_SLOT_LAST 5'h1f
`define RPS_FLAG_OFS_LO 5'h01
`define RPS_FLAG_OFS_HI 5'h02
// Digital milliwatt sequences, first byte in the low lane
`define RPS_DMW_A 64'hb4a1a1b434212134
`define RPS_DMW_MU 64'h9e8b8b9e1e0b0b1e
// Indirect access duration in clock cycles
`define RPS_ACC_CYC 2
`endif

// File: rps_pkg.sv
// Types shared by the rx payload and signaling control block
package rps_pkg;
    typedef logic [4:0] rps_slot_type;
    typedef logic [7:0] rps_byte_type;
    typedef logic [3:0] rps_abcd_type;
    typedef enum logic {SEQ_IDLE, SEQ_RUN} rps_seq_state_type;
endpackage

// File: rps_access_seq.sv
// Busy sequencer for one indirect access window
`timescale 1ns/1ps
`include "rps_defs.svh"
module rps_access_seq #(
    parameter int CYCLES = `RPS_ACC_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Access request and progress
    input wire logic start_i,
    output logic busy_o,
    output logic fire_o
);
    import rps_pkg::*;
    localparam int CW = $clog2(CYCLES + 1);

    rps_seq_state_type state;
    logic [CW-1:0] cnt;

    if (CYCLES < 1) begin : g_chk
        $error("CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy spans the whole access; fire marks its last cycle
    assign busy_o = (state == SEQ_RUN);
    assign fire_o = (state == SEQ_RUN) && (cnt == '0);

    // Sequence state; a start while busy is not seen here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SEQ_IDLE;
            cnt <= '0;
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                    if (start_i) begin
                        state <= SEQ_RUN;
                        cnt <= CW'(CYCLES - 1);
                    end
                end
                SEQ_RUN: begin
                    if (cnt == '0) begin
                        state <= SEQ_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_fire_ends: assert property (@(posedge clk_i) disable iff (rst_i)
        fire_o |=> !busy_o) else $error("busy outlived its access");
    a_start_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        start_i && !busy_o |=> busy_o) else $error("busy not raised");
endmodule

// File: rps_host_model.sv
// Host processor model driving the Wishbone register port
`timescale 1ns/1ps
module rps_host_model (
    // Clock
    input wire logic clk_i,
    // Wishbone master side
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [9:0] adr_o,
    output logic [31:0] dat_o
);
    // Bus idle from time zero
    initial begin
        {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
    end
    // One classic cycle; request held until ack is sampled high.
    // No cycle limit here: only the bench watchdog ends a stuck wait.
    task automatic xfer(input logic w, input logic [7:0] ix,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= {ix, 2'h0};
        dat_o <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
    // Poll the status register that sits just below a control register
    task automatic wait_idle(input logic [7:0] ctl);
        logic [7:0] s;
        do begin
            xfer(1'b0, ctl - 8'h01, 8'h00, s);
        end while (s[0] !== 1'b0);
    endtask
    // Indirect write: data first, then address with direction 0
    task automatic ind_wr(input logic [7:0] ctl, input logic [6:0] a,
                          input logic [7:0] d);
        logic [7:0] q;
        wait_idle(ctl);
        xfer(1'b1, ctl + 8'h01, d, q);
        xfer(1'b1, ctl, {1'b0, a}, q);
        wait_idle(ctl);
    endtask
    // Indirect read: address with direction 1, wait, fetch data byte
    task automatic ind_rd(input logic [7:0] ctl, input logic [6:0] a,
                          output logic [7:0] q);
        wait_idle(ctl);
        xfer(1'b1, ctl, {1'b1, a}, q);
        wait_idle(ctl);
        xfer(1'b0, ctl + 8'h01, 8'h00, q);
    endtask
endmodule

// File: testbench.sv
// Self-checking bench for the rx payload and signaling control block
`timescale 1ns/1ps
`include "rps_defs.svh"
module testbench;
    import rps_pkg::*;
    typedef struct {logic [7:0] cfg; logic [7:0] en; rps_byte_type e;}
        rps_row_type;
    logic clk_i, rst_i, cyc, stb, we, ack, pay_v, sig_v, sig_first;
    logic mf_sync, pv_o, sv_o, irq, tx_en;
    logic [9:0] adr;
    logic [31:0] wdat, rdat;
    rps_slot_type pay_slot, sig_slot;
    rps_byte_type pay_data, pay_o, q;
    rps_abcd_type sig_abcd, sig_o;
    int error_cnt, num_checks;
    rps_row_type rows[6] = '{'{8'h00, 8'h00, 8'h77}, '{8'h00, 8'h01, 8'h1e},
        '{8'h01, 8'h01, 8'h5a}, '{8'h02, 8'h01, 8'h34},
        '{8'h03, 8'h01, 8'h1e}, '{8'h07, 8'h01, 8'h77}};
    ////////////////////////////////////////////////////////////////////////
    // Long access time so busy can be seen from the bus
    rps_top #(.ACC_CYCLES(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pay_v_i(pay_v), .pay_slot_i(pay_slot), .pay_data_i(pay_data),
        .rx_payload_valid_o(pv_o), .rx_payload_o(pay_o), .sig_v_i(sig_v),
        .sig_slot_i(sig_slot), .sig_abcd_i(sig_abcd),
        .sig_first_i(sig_first), .mf_sync_i(mf_sync), .rx_sig_valid_o(sv_o),
        .rx_signaling_out_o(sig_o), .irq_o(irq), .tx_payload_ctrl_en_o(tx_en));
    rps_host_model host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat));
    ////////////////////////////////////////////////////////////////////////
    // Clock at 125 MHz
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        finish_test();
    end
    task automatic finish_test;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        host_u.xfer(1'b1, ix, d, q);
    endtask
    task automatic rd(input logic [7:0] ix, input logic [7:0] e);
        host_u.xfer(1'b0, ix, 8'h00, q);
        chk("register", e, q);
    endtask
    // One payload byte, result one cycle after it is taken
    task automatic pay(input rps_slot_type s, input rps_byte_type e);
        @(posedge clk_i);
        pay_v <= 1'b1;
        pay_slot <= s;
        pay_data <= 8'h77;
        @(posedge clk_i);
        pay_v <= 1'b0;
        #1;
        chk("payload valid", 8'h01, {7'h0, pv_o});
        chk("payload byte", e, pay_o);
    endtask
    // One signaling codeword, result one cycle after it is taken
    task automatic sig(input rps_slot_type s, input rps_abcd_type a,
                       input logic f, input rps_abcd_type e);
        @(posedge clk_i);
        sig_v <= 1'b1;
        sig_slot <= s;
        sig_abcd <= a;
        sig_first <= f;
        @(posedge clk_i);
        sig_v <= 1'b0;
        #1;
        chk("signaling out", {4'h0, e}, {4'h0, sig_o});
        chk("signaling valid", 8'h01, {7'h0, sv_o});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        error_cnt = 0;
        num_checks = 0;
        {rst_i, pay_v, sig_v, sig_first, mf_sync} = 5'h10;
        {pay_slot, pay_data, sig_slot, sig_abcd} = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 8'hcc; i <= 8'hd9; i++) begin
            rd(8'(i), 8'h00);
        end
        wr(`RPS_IX_TXEN, 8'hff);
        rd(`RPS_IX_TXEN, 8'h01);
        chk("tx enable", 8'h01, {7'h0, tx_en});
        wr(`RPS_IX_TXEN, 8'h00);
        chk("tx enable", 8'h00, {7'h0, tx_en});
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        // Indirect stores, holes refused
        host_u.ind_wr(`RPS_IX_PCTL, 7'h25, 8'h5a);
        host_u.ind_wr(`RPS_IX_PCTL, 7'h05, 8'h60);
        host_u.ind_wr(`RPS_IX_PCTL, 7'h40, 8'hff);
        host_u.ind_rd(`RPS_IX_PCTL, 7'h40, q);
        chk("payload hole", 8'h00, q);
        host_u.ind_wr(`RPS_IX_SCTL, 7'h10, 8'h0f);
        host_u.ind_rd(`RPS_IX_SCTL, 7'h10, q);
        chk("signaling hole", 8'h00, q);
        wr(`RPS_IX_PCTL, 8'h85);
        rd(`RPS_IX_PSTAT, 8'h01);
        host_u.wait_idle(`RPS_IX_PCTL);
        rd(`RPS_IX_PDAT, 8'h60);
        rd(`RPS_IX_PCTL, 8'h85);
        host_u.ind_rd(`RPS_IX_PCTL, 7'h25, q);
        chk("trunk code", 8'h5a, q);
        // Selector table on timeslot 5
        foreach (rows[i]) begin
            wr(`RPS_IX_PCFG, rows[i].cfg);
            wr(`RPS_IX_PEN, rows[i].en);
            pay(5'h05, rows[i].e);
        end
        // Milliwatt phase steps after the last slot of a frame
        pay(5'h1f, 8'h77);
        wr(`RPS_IX_PCFG, 8'h03);
        pay(5'h05, 8'h0b);
        // Change flags, mapping and interrupt
        wr(`RPS_IX_PCFG, 8'h00);
        wr(`RPS_IX_SCFG, 8'h02);
        sig(5'h11, 4'h5, 1'b0, 4'h5);
        rd(`RPS_IX_CHG1, 8'h80);
        chk("irq", 8'h01, {7'h0, irq});
        wr(`RPS_IX_CHG1, 8'h00);
        rd(`RPS_IX_CHG1, 8'h80);
        wr(`RPS_IX_CHG1, 8'h80);
        rd(`RPS_IX_CHG1, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        sig(5'h01, 4'h3, 1'b0, 4'h3);
        sig(5'h1a, 4'h3, 1'b0, 4'h3);
        rd(`RPS_IX_CHG0, 8'h01);
        rd(`RPS_IX_CHG3, 8'h01);
        wr(`RPS_IX_CHG0, 8'h01);
        rd(`RPS_IX_CHG0, 8'h00);
        wr(`RPS_IX_SCFG, 8'h00);
        rd(`RPS_IX_SCFG, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        // Freeze then debounce
        wr(`RPS_IX_SCFG, 8'h08);
        sig(5'h02, 4'h9, 1'b0, 4'h9);
        host_u.ind_rd(`RPS_IX_SCTL, 7'h02, q);
        chk("frozen abcd", 8'h00, q);
        wr(`RPS_IX_SCFG, 8'h04);
        sig(5'h03, 4'h6, 1'b0, 4'h6);
        host_u.ind_rd(`RPS_IX_SCTL, 7'h03, q);
        chk("one codeword", 8'h00, q);
        sig(5'h03, 4'h6, 1'b0, 4'h6);
        host_u.ind_rd(`RPS_IX_SCTL, 7'h03, q);
        chk("two codewords", 8'h06, q);
        // Trunk conditioning per slot and global
        wr(`RPS_IX_SCFG, 8'h00);
        host_u.ind_wr(`RPS_IX_PCTL, 7'h44, 8'h1a);
        host_u.ind_wr(`RPS_IX_PCTL, 7'h46, 8'h0c);
        sig(5'h04, 4'h3, 1'b0, 4'ha);
        sig(5'h06, 4'h3, 1'b0, 4'h3);
        wr(`RPS_IX_PCFG, 8'h40);
        sig(5'h06, 4'h3, 1'b0, 4'hc);
        // Snapshot of the first frame across the multiframe
        wr(`RPS_IX_PCFG, 8'h80);
        @(posedge clk_i);
        mf_sync <= 1'b1;
        sig(5'h07, 4'h5, 1'b1, 4'h5);
        sig(5'h07, 4'h9, 1'b0, 4'h5);
        finish_test();
    end
endmodule
